// ===== reset_source_control_pkg.sv
package reset_source_control_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [11:0] OFF_PART_IDENTITY = 12'h000;
	localparam logic [11:0] OFF_RESET_CAUSE = 12'h004;
	localparam logic [11:0] OFF_ONESHOT = 12'h008;
	localparam logic [11:0] OFF_PERIPH = 12'h00c;
	localparam logic [11:0] OFF_LOCK_KEY = 12'h100;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int POS_CORE_ONESHOT_FLAG = 7;
	localparam int POS_CORE_REQUEST_FLAG = 5;
	localparam int POS_BROWNOUT_FLAG = 4;
	localparam int POS_WATCHDOG_FLAG = 2;
	localparam int POS_PIN_RESET_FLAG = 1;
	localparam int POS_POWER_ON_FLAG = 0;
	localparam int POS_CORE_ONESHOT = 1;
	localparam int POS_CHIP_ONESHOT = 0;
	localparam int POS_LOCK_OPEN = 0;

	// writable / readable masks
	localparam logic [31:0] CAUSE_MASK = 32'h0000_00b7;
	localparam logic [31:0] ONESHOT_MASK = 32'h0000_0003;
	localparam logic [31:0] PERIPH_MASK = 32'h1051_110e;

	// ----------------------------------------
	// reset values and constants
	// ----------------------------------------
	localparam logic [31:0] PERIPH_RESET = 32'h0000_0000;
	localparam logic [31:0] ONESHOT_RESET = 32'h0000_0000;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	localparam logic [7:0] KEY_FIRST = 8'h59;
	localparam logic [7:0] KEY_SECOND = 8'h16;
	localparam logic [7:0] KEY_THIRD = 8'h88;
	// one-shot pulse length in clocks
	localparam logic [1:0] ONESHOT_CYCLES = 2'd2;
	// arbitrary neutral part code
	localparam logic [31:0] PART_CODE_DEFAULT = 32'h0000_0a5c;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {KEY_IDLE, KEY_GOT1, KEY_GOT2, KEY_OPEN} key_state_t;

	// reset-cause pulses from the rest of the chip
	typedef struct packed {
		logic powerOn;
		logic pinReset;
		logic watchdog;
		logic brownout;
		logic coreRequest;
	} cause_events_t;

	// peripheral reset outputs
	typedef struct packed {
		logic converter;
		logic comparator;
		logic pulseWidth;
		logic uart;
		logic spi;
		logic i2c;
		logic timer1;
		logic timer0;
		logic gpio;
	} periph_resets_t;

endpackage

// ===== reset_source_control.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module reset_source_control #(
	parameter logic [31:0] PART_CODE = reset_source_control_pkg::PART_CODE_DEFAULT
) (
	input wire logic clock,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// reset cause pulses
	input wire reset_source_control_pkg::cause_events_t causeEvents,
	// one-shot reset requests to the reset generator
	output logic coreOneshotReset,
	output logic chipOneshotReset,
	// held peripheral resets
	output reset_source_control_pkg::periph_resets_t periphResets
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [11:0] awAddr_r; // latched write address
	logic awHeld_r; // write address captured
	logic [31:0] wData_r; // latched write data
	logic [3:0] wStrb_r; // latched strobes
	logic wHeld_r; // write data captured
	logic [7:0] causeFlags_r; // sticky reset causes
	logic [1:0] oneshot_r; // one-shot control bits
	logic [1:0] coreCount_r; // core pulse countdown
	logic [1:0] chipCount_r; // chip pulse countdown
	logic [31:0] periph_r; // peripheral reset control
	reset_source_control_pkg::key_state_t keyState_r; // unlock progress
	logic doWrite; // write commits this cycle
	logic doRead; // read accepted this cycle
	logic hitKey; // write goes to lock key
	logic hitOneshot; // write goes to one-shot control
	logic hitCause; // write goes to cause flags
	logic hitPeriph; // write goes to peripheral control
	logic unlocked; // protected bits open
	logic [7:0] causeSet; // hardware events this cycle
	logic [31:0] readWord; // read mux
	logic readOk; // read address mapped

	// every check in this block runs on the one clock, idle during reset
	default clocking assertClk @(posedge clock); endclocking
	default disable iff (rst);

	// full-word check; narrow writes to protected regs are refused
	function automatic logic fullWord(input logic [3:0] strb);
		fullWord = (strb == 4'hf);
	endfunction

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
	assign hitKey = (awAddr_r == reset_source_control_pkg::OFF_LOCK_KEY);
	assign hitOneshot = (awAddr_r == reset_source_control_pkg::OFF_ONESHOT);
	assign hitCause = (awAddr_r == reset_source_control_pkg::OFF_RESET_CAUSE);
	assign hitPeriph = (awAddr_r == reset_source_control_pkg::OFF_PERIPH);
	assign unlocked = (keyState_r == reset_source_control_pkg::KEY_OPEN);

	// address and data taken in either order, one write in flight
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			awHeld_r <= 1'b0;
			awAddr_r <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_r <= 1'b1;
			awAddr_r <= {s_axi_awaddr[11:2], 2'b00};
		end else if (doWrite) begin
			awHeld_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wHeld_r <= 1'b0;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_r <= 1'b1;
			wData_r <= s_axi_wdata;
			wStrb_r <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld_r <= 1'b0;
		end
	end

	// ready only while the slot is empty
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !awHeld_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !wHeld_r && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// response; unmapped offsets answer slverr
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= reset_source_control_pkg::RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			if (hitKey || hitOneshot || hitCause || hitPeriph ||
				awAddr_r == reset_source_control_pkg::OFF_PART_IDENTITY) begin
				s_axi_bresp <= reset_source_control_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= reset_source_control_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// lock key sequencer
	// ----------------------------------------
	// any write but the next key byte breaks a partial sequence; key writes use low byte
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			keyState_r <= reset_source_control_pkg::KEY_IDLE;
		end else if (doWrite) begin
			case (keyState_r)
				reset_source_control_pkg::KEY_IDLE: begin
					if (hitKey && wData_r[7:0] == reset_source_control_pkg::KEY_FIRST)
						keyState_r <= reset_source_control_pkg::KEY_GOT1;
				end
				reset_source_control_pkg::KEY_GOT1: begin
					if (hitKey && wData_r[7:0] == reset_source_control_pkg::KEY_SECOND)
						keyState_r <= reset_source_control_pkg::KEY_GOT2;
					else
						keyState_r <= reset_source_control_pkg::KEY_IDLE;
				end
				reset_source_control_pkg::KEY_GOT2: begin
					if (hitKey && wData_r[7:0] == reset_source_control_pkg::KEY_THIRD)
						keyState_r <= reset_source_control_pkg::KEY_OPEN;
					else
						keyState_r <= reset_source_control_pkg::KEY_IDLE;
				end
				default: begin
					// other writes leave it open; key write relocks
					if (hitKey)
						keyState_r <= reset_source_control_pkg::KEY_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// one-shot resets
	// ----------------------------------------
	// bit stays 1 for two clocks then drops; writes of 0 ignored
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			coreCount_r <= 2'd0;
			chipCount_r <= 2'd0;
			oneshot_r <= 2'b00;
		end else begin
			if (doWrite && hitOneshot && unlocked && fullWord(wStrb_r) &&
				wData_r[reset_source_control_pkg::POS_CORE_ONESHOT]) begin
				coreCount_r <= reset_source_control_pkg::ONESHOT_CYCLES;
				oneshot_r[reset_source_control_pkg::POS_CORE_ONESHOT] <= 1'b1;
			end else if (coreCount_r > 2'd1) begin
				coreCount_r <= coreCount_r - 2'd1;
			end else begin
				coreCount_r <= 2'd0;
				oneshot_r[reset_source_control_pkg::POS_CORE_ONESHOT] <= 1'b0;
			end
			if (doWrite && hitOneshot && unlocked && fullWord(wStrb_r) &&
				wData_r[reset_source_control_pkg::POS_CHIP_ONESHOT]) begin
				chipCount_r <= reset_source_control_pkg::ONESHOT_CYCLES;
				oneshot_r[reset_source_control_pkg::POS_CHIP_ONESHOT] <= 1'b1;
			end else if (chipCount_r > 2'd1) begin
				chipCount_r <= chipCount_r - 2'd1;
			end else begin
				chipCount_r <= 2'd0;
				oneshot_r[reset_source_control_pkg::POS_CHIP_ONESHOT] <= 1'b0;
			end
		end
	end

	// outputs follow the bits; chip pulse goes to the power-on path
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			coreOneshotReset <= 1'b0;
			chipOneshotReset <= 1'b0;
		end else begin
			coreOneshotReset <= oneshot_r[reset_source_control_pkg::POS_CORE_ONESHOT];
			chipOneshotReset <= oneshot_r[reset_source_control_pkg::POS_CHIP_ONESHOT];
		end
	end

	// ----------------------------------------
	// reset cause flags
	// ----------------------------------------
	// flags live outside the chip reset scope, so rst clears only to zero
	always_comb begin
		causeSet = 8'h00;
		causeSet[reset_source_control_pkg::POS_CORE_ONESHOT_FLAG] =
			oneshot_r[reset_source_control_pkg::POS_CORE_ONESHOT];
		causeSet[reset_source_control_pkg::POS_CORE_REQUEST_FLAG] =
			causeEvents.coreRequest;
		causeSet[reset_source_control_pkg::POS_BROWNOUT_FLAG] =
			causeEvents.brownout;
		causeSet[reset_source_control_pkg::POS_WATCHDOG_FLAG] =
			causeEvents.watchdog;
		causeSet[reset_source_control_pkg::POS_PIN_RESET_FLAG] =
			causeEvents.pinReset;
		causeSet[reset_source_control_pkg::POS_POWER_ON_FLAG] =
			causeEvents.powerOn ||
			oneshot_r[reset_source_control_pkg::POS_CHIP_ONESHOT];
	end

	// set wins over a same-cycle write-one clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			causeFlags_r <= reset_source_control_pkg::CAUSE_RESET;
		end else if (doWrite && hitCause && wStrb_r[0]) begin
			causeFlags_r <= (causeFlags_r & ~wData_r[7:0]) | causeSet;
		end else begin
			causeFlags_r <= causeFlags_r | causeSet;
		end
	end

	// ----------------------------------------
	// peripheral resets
	// ----------------------------------------
	// per-byte strobes honoured; reserved bits masked off
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			periph_r <= reset_source_control_pkg::PERIPH_RESET;
		end else if (doWrite && hitPeriph) begin
			for (int b = 0; b < 4; b++) begin
				if (wStrb_r[b])
					periph_r[b*8 +: 8] <= wData_r[b*8 +: 8] &
						reset_source_control_pkg::PERIPH_MASK[b*8 +: 8];
			end
		end
	end

	// registered drive to each block
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			periphResets <= '0;
		end else begin
			periphResets.converter <= periph_r[28];
			periphResets.comparator <= periph_r[22];
			periphResets.pulseWidth <= periph_r[20];
			periphResets.uart <= periph_r[16];
			periphResets.spi <= periph_r[12];
			periphResets.i2c <= periph_r[8];
			periphResets.timer1 <= periph_r[3];
			periphResets.timer0 <= periph_r[2];
			periphResets.gpio <= periph_r[1];
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always_comb begin
		readWord = 32'h0000_0000;
		readOk = 1'b1;
		if (s_axi_araddr[11:2] == reset_source_control_pkg::OFF_PART_IDENTITY[11:2]) begin
			readWord = PART_CODE;
		end else if (s_axi_araddr[11:2] == reset_source_control_pkg::OFF_RESET_CAUSE[11:2]) begin
			readWord = {24'h000000, causeFlags_r};
		end else if (s_axi_araddr[11:2] == reset_source_control_pkg::OFF_ONESHOT[11:2]) begin
			readWord = {30'h0, oneshot_r};
		end else if (s_axi_araddr[11:2] == reset_source_control_pkg::OFF_PERIPH[11:2]) begin
			readWord = periph_r;
		end else if (s_axi_araddr[11:2] == reset_source_control_pkg::OFF_LOCK_KEY[11:2]) begin
			readWord = {31'h0, unlocked};
		end else begin
			readOk = 1'b0;
		end
	end

	assign doRead = s_axi_arvalid && s_axi_arready;

	// single read in flight; answer one clock after address
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= reset_source_control_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !doRead;
			if (doRead) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= readWord;
				s_axi_rresp <= readOk ? reset_source_control_pkg::RESP_OKAY :
					reset_source_control_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	// a re-trigger cannot land inside a pulse: commits are three clocks apart
	property p_core_pulse;
		$rose(oneshot_r[1]) |-> oneshot_r[1] ##1 oneshot_r[1] ##1 !oneshot_r[1];
	endproperty
	a_core_pulse: assert property (p_core_pulse) else $error("core one-shot length");
	property p_chip_pulse;
		$rose(oneshot_r[0]) |-> oneshot_r[0] ##1 oneshot_r[0] ##1 !oneshot_r[0];
	endproperty
	a_chip_pulse: assert property (p_chip_pulse) else $error("chip one-shot length");
	property p_locked_no_shot;
		(doWrite && hitOneshot && !unlocked) |=> !$rose(oneshot_r[1]) && !$rose(oneshot_r[0]);
	endproperty
	a_locked_no_shot: assert property (p_locked_no_shot) else $error("locked write fired");
	property p_core_flag;
		oneshot_r[1] |=> causeFlags_r[7];
	endproperty
	a_core_flag: assert property (p_core_flag) else $error("core flag not set");
	property p_por_flag;
		(causeEvents.powerOn || oneshot_r[0]) |=> causeFlags_r[0];
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("power-on flag not set");
	property p_wdt_flag;
		causeEvents.watchdog |=> causeFlags_r[2];
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");
	property p_sticky;
		(causeFlags_r[4] && !(doWrite && hitCause)) |=> causeFlags_r[4];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");
	property p_abort;
		(doWrite && !hitKey && keyState_r == reset_source_control_pkg::KEY_GOT1)
			|=> keyState_r == reset_source_control_pkg::KEY_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("unlock not aborted");
	property p_relock;
		(doWrite && hitKey && unlocked) |=> !unlocked;
	endproperty
	a_relock: assert property (p_relock) else $error("no relock");
	property p_periph_out;
		periph_r[12] |=> periphResets.spi;
	endproperty
	a_periph_out: assert property (p_periph_out) else $error("spi reset not driven");
	property p_reserved;
		(periph_r & ~reset_source_control_pkg::PERIPH_MASK) == 32'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	c_unlock: cover property ($rose(unlocked));
	c_chip: cover property ($rose(chipOneshotReset));
	c_clear: cover property ($fell(causeFlags_r[0]));

endmodule // reset_source_control

`default_nettype wire

// ===== reset_far_side.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// far side: reset-cause sources and the
// reset generator that sees the one-shots
// ----------------------------------------
module reset_far_side (
	input wire logic clock,
	input wire logic rst,
	output var reset_source_control_pkg::cause_events_t causeEvents,
	input wire logic coreOneshotReset,
	input wire logic chipOneshotReset
);
	int coreRun; // cycles of the running core pulse
	int chipRun; // cycles of the running chip pulse
	int coreLen; // length of the last core pulse
	int chipLen; // length of the last chip pulse
	int corePulses; // core pulses seen so far
	int chipPulses; // chip pulses seen so far

	// sources idle until a pulse is asked for
	initial begin
		causeEvents = '0;
	end

	// one-cycle cause pulse, launched just after an edge
	task automatic pulse(input reset_source_control_pkg::cause_events_t ev);
		@(posedge clock);
		causeEvents <= ev;
		@(posedge clock);
		causeEvents <= '0;
	endtask

	// measure one-shot widths as the reset generator would
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			coreRun <= 0;
			coreLen <= 0;
			corePulses <= 0;
		end else if (coreOneshotReset) begin
			coreRun <= coreRun + 1;
		end else if (coreRun != 0) begin
			// falling end of a pulse
			coreLen <= coreRun;
			corePulses <= corePulses + 1;
			coreRun <= 0;
		end
	end

	// chip one-shot is taken as a power-on by the generator
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			chipRun <= 0;
			chipLen <= 0;
			chipPulses <= 0;
		end else if (chipOneshotReset) begin
			chipRun <= chipRun + 1;
		end else if (chipRun != 0) begin
			chipLen <= chipRun;
			chipPulses <= chipPulses + 1;
			chipRun <= 0;
		end
	end
endmodule // reset_far_side

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	// arbitrary part code, not a real device value
	localparam logic [31:0] ID_CODE = 32'h0000_3c61;
	logic clock;
	logic rst;
	logic [11:0] awaddr;
	logic awvalid;
	logic awready;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic wvalid;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready;
	logic [11:0] araddr;
	logic arvalid;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready;
	reset_source_control_pkg::cause_events_t causeEvents;
	logic coreOs;
	logic chipOs;
	reset_source_control_pkg::periph_resets_t periphResets;
	int badCount = 0;
	int samplesChecked = 0;
	int cycles = 0;
	logic [1:0] rsp;
	logic [31:0] d;
	logic [31:0] expv;
	int pos[5] = '{0, 1, 2, 4, 5};
	int pbit[9] = '{28, 22, 20, 16, 12, 8, 3, 2, 1};

	reset_source_control #(.PART_CODE(ID_CODE)) u_dut (
		.clock(clock), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.causeEvents(causeEvents), .coreOneshotReset(coreOs),
		.chipOneshotReset(chipOs), .periphResets(periphResets)
	);

	reset_far_side u_src (
		.clock(clock), .rst(rst), .causeEvents(causeEvents),
		.coreOneshotReset(coreOs), .chipOneshotReset(chipOs)
	);

	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// the whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			badCount++;
			completeRun();
		end
	end

	// ----------------------------------------
	// bus tasks and comparison
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			badCount++;
		end
	endtask

	// address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic awDone;
		logic wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge clock);
			if (!awDone && awready === 1'b1) begin
				awDone = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wDone && wready === 1'b1) begin
				wDone = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// bready stays high, so the sampled edge is the answer
		while (bvalid !== 1'b1) @(posedge clock);
		rsp = bresp;
	endtask

	task automatic rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		d = rdata;
		rsp = rresp;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		rd(a);
		check(d, exp);
	endtask

	task automatic completeRun();
		$display("checks=%0d mismatches=%0d", samplesChecked, badCount);
		if (badCount == 0 && samplesChecked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = 4'hf;
		wvalid = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		// responses always accepted at once
		bready = 1'b1;
		rready = 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		// reset values, identity, unmapped place
		rchk(12'h000, ID_CODE);
		check(32'(rsp), 32'(reset_source_control_pkg::RESP_OKAY));
		wr(12'h000, 32'hffff_ffff);
		check(32'(rsp), 32'(reset_source_control_pkg::RESP_OKAY));
		rchk(12'h000, ID_CODE);
		rchk(12'h004, 32'h0);
		rchk(12'h008, 32'h0);
		rchk(12'h00c, 32'h0);
		rchk(12'h100, 32'h0);
		rchk(12'h010, 32'h0);
		check(32'(rsp), 32'(reset_source_control_pkg::RESP_SLVERR));
		wr(12'h010, 32'hffff_ffff);
		check(32'(rsp), 32'(reset_source_control_pkg::RESP_SLVERR));
		$display("test reset_values done");
		// each hardware cause sets its own flag
		expv = 32'h0;
		for (int i = 0; i < 5; i++) begin
			u_src.pulse(reset_source_control_pkg::cause_events_t'(5'h10 >> i));
			expv[pos[i]] = 1'b1;
			rchk(12'h004, expv);
		end
		wr(12'h004, 32'h0);
		rchk(12'h004, expv);
		wr(12'h004, 32'h4);
		rchk(12'h004, expv & ~32'h4);
		wr(12'h004, 32'hffff_ffff);
		rchk(12'h004, 32'h0);
		$display("test cause_flags done");
		// locked one-shot write has no effect
		wr(12'h008, 32'h2);
		repeat (4) @(posedge clock);
		check(32'(u_src.corePulses), 32'd0);
		// wrong byte, then a foreign write, both abort
		wr(12'h100, 32'h59);
		wr(12'h100, 32'h00);
		wr(12'h100, 32'h16);
		wr(12'h100, 32'h88);
		rchk(12'h100, 32'h0);
		wr(12'h100, 32'h59);
		wr(12'h00c, 32'h0);
		wr(12'h100, 32'h16);
		wr(12'h100, 32'h88);
		rchk(12'h100, 32'h0);
		wr(12'h100, 32'h59);
		wr(12'h100, 32'h16);
		wr(12'h100, 32'h88);
		rchk(12'h100, 32'h1);
		wr(12'h008, 32'h2);
		repeat (4) @(posedge clock);
		check(32'(u_src.corePulses), 32'd1);
		check(32'(u_src.coreLen), 32'd2);
		check(32'(u_src.chipPulses), 32'd0);
		rchk(12'h008, 32'h0);
		rchk(12'h004, 32'h80);
		wr(12'h008, 32'h1);
		repeat (4) @(posedge clock);
		check(32'(u_src.chipPulses), 32'd1);
		check(32'(u_src.chipLen), 32'd2);
		rchk(12'h004, 32'h81);
		rchk(12'h100, 32'h1);
		wr(12'h100, 32'h0);
		rchk(12'h100, 32'h0);
		wr(12'h008, 32'h3);
		repeat (4) @(posedge clock);
		check(32'(u_src.corePulses + u_src.chipPulses), 32'd2);
		$display("test oneshot_lock done");
		// peripheral resets held until written zero
		wr(12'h00c, 32'hffff_ffff);
		rchk(12'h00c, reset_source_control_pkg::PERIPH_MASK);
		check(32'(periphResets), 32'h1ff);
		// low byte only: timers and gpio released, the rest held
		wstrb <= 4'h1;
		wr(12'h00c, 32'h0);
		rchk(12'h00c, 32'h1051_1100);
		check(32'(periphResets), 32'h1f8);
		wstrb <= 4'hf;
		for (int i = 0; i < 9; i++) begin
			wr(12'h00c, 32'h1 << pbit[i]);
			rchk(12'h00c, 32'h1 << pbit[i]);
			check(32'(periphResets), 32'h100 >> i);
		end
		wr(12'h00c, 32'h0);
		rchk(12'h00c, 32'h0);
		check(32'(periphResets), 32'h0);
		$display("test periph_resets done");
		completeRun();
	end
endmodule // tb_top

`default_nettype wire
